// File: smag_guard.sv
// Access guard between the CPU core and its peripheral control registers.
// Assumes the CPU holds mode, address and strobes valid for one cycle per access;
// the factory phase input comes from the same clock domain, and the exception
// logic takes the one-cycle violation pulse at the next edge without polling.
`timescale 1ns/100ps

module smag_guard
    import smag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic test_end_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [SMAG_AW-1:0] addr_i,
    input wire logic [SMAG_DW-1:0] wdata_i,
    output logic [SMAG_DW-1:0] rdata_o,
    output logic rvalid_o,
    output logic violation_o,
    output logic [SMAG_DW-1:0] seg_ptr_o,
    output logic [SMAG_DW-1:0] seg_en_o,
    output logic [SMAG_DW-1:0] cless_part_o
);
    // ********************************************************
    // Decode
    // ********************************************************
    // Decode results, held registers and answer state
    smag_mode_e mode;
    logic in_cpu, in_mmu, in_per, in_part, in_fcd;
    logic [SMAG_FCD_IW-1:0] per_idx;
    logic allow;
    logic acc;
    logic [SMAG_DW-1:0] regs [SMAG_NREG];
    logic [SMAG_DW-1:0] fcd_rdata;
    logic fcd_rd_q;
    logic [SMAG_DW-1:0] reg_rdata_q;
    logic reg_wr_ok;

    // Address map, one byte per address:
    //   CPU core registers, open in every mode
    //   MMU block: segment pointer, segment enables, user grants, contactless grants,
    //     reachable from system mode only
    //   Peripheral registers: system mode, or user/contactless mode with its grant bit
    //   Contactless partition: a read-only constant, never writable
    //   Factory check data: stored in test mode at the end of test, read back later
    //   Anything else is unmapped and always refused
    // Held register index is the low address bits inside the first sixteen bytes.
    // The mode field uses all four codes, so the cast below cannot yield a stray value.
    assign mode = smag_mode_e'(mode_i);
    // Region flags; the ranges are disjoint, so at most one of them is high
    assign acc = rd_i | wr_i;
    assign in_cpu = (addr_i >= SMAG_CPU_LO) && (addr_i <= SMAG_CPU_HI);
    assign in_mmu = (addr_i >= SMAG_MMU_LO) && (addr_i <= SMAG_MMU_HI);
    assign in_per = (addr_i >= SMAG_PER_LO) && (addr_i <= SMAG_PER_HI);
    assign in_part = (addr_i == SMAG_CLESS_PART);
    assign in_fcd = (addr_i >= SMAG_FCD_LO) && (addr_i <= SMAG_FCD_HI);
    assign per_idx = addr_i[SMAG_FCD_IW-1:0];

    // combinational decision
    // Hard-wired attribute table; only the grant bits vary
    // Grant bits are read as they stand before the edge, so a grant written by one
    // access governs the next access, never the one that writes it.
    always_comb begin
        allow = 1'b0;
        if (in_cpu) begin
            allow = 1'b1;
        end else if (in_mmu) begin
            allow = (mode == SMAG_SYSTEM);
        end else if (in_per) begin
            case (mode)
                SMAG_SYSTEM: allow = 1'b1;
                SMAG_USER: allow = regs[SMAG_UGRANT[SMAG_IW-1:0]][per_idx];
                SMAG_CLESS: allow = regs[SMAG_CGRANT[SMAG_IW-1:0]][per_idx];
                // Test mode reaches no peripheral register
                default: allow = 1'b0;
            endcase
        end else if (in_part) begin
            // readable, never writable
            // A read paired with a write counts as a write, so it is refused
            allow = rd_i && !wr_i;
        end else if (in_fcd) begin
            // store in test mode at end of test
            if (wr_i) begin
                // A read beside the write would be ambiguous; refuse the pair
                allow = (mode == SMAG_TEST) && test_end_i && !rd_i;
            end else begin
                // check in system or user mode
                allow = (mode == SMAG_SYSTEM) || (mode == SMAG_USER);
            end
        end
    end

    // ********************************************************
    // Register file
    // ********************************************************
    // One flop group per held register. Each entry answers to its own index only,
    // so a refused or unmapped write can never spill into a neighbour, and each
    // entry's reset value is fixed at elaboration.
    assign reg_wr_ok = wr_i && allow && (in_cpu || in_mmu || in_per);

    for (genvar g = 0; g < SMAG_NREG; g++) begin : g_reg
        localparam logic [SMAG_IW-1:0] IDX = SMAG_IW'(g);
        localparam logic [SMAG_DW-1:0] RST_VAL =
            (IDX == SMAG_SEG_EN[SMAG_IW-1:0]) ? SMAG_SEG_EN_RST :
            ((IDX == SMAG_UGRANT[SMAG_IW-1:0]) || (IDX == SMAG_CGRANT[SMAG_IW-1:0])) ?
            SMAG_GRANT_RST : SMAG_REG_RST;

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                regs[g] <= RST_VAL;
            end else if (reg_wr_ok && (addr_i[SMAG_IW-1:0] == IDX)) begin
                regs[g] <= wdata_i;
            end
        end
    end

    // Factory check data store
    // Its write enable already carries the guard's decision, so it stores blindly
    smag_fcd_mem u_fcd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_i && allow && in_fcd),
        .addr_i(addr_i[SMAG_FCD_IW-1:0]),
        .wdata_i(wdata_i),
        .rdata_o(fcd_rdata)
    );

    // ********************************************************
    // Answers
    // ********************************************************
    // read answered next cycle
    // A combined read and write is treated as a write, so it gets no read answer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i && !wr_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fcd_rd_q <= 1'b0;
        end else begin
            fcd_rd_q <= rd_i && allow && in_fcd;
        end
    end

    // refused reads give zero
    // Zero rather than a stale value, so a refused read leaks nothing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_q <= SMAG_ZERO;
        end else if (rd_i && allow && (in_cpu || in_mmu || in_per)) begin
            reg_rdata_q <= regs[addr_i[SMAG_IW-1:0]];
        end else if (rd_i && allow && in_part) begin
            reg_rdata_q <= SMAG_CLESS_PART_VAL;
        end else begin
            reg_rdata_q <= SMAG_ZERO;
        end
    end

    // The factory store already registers its read data, so the last step is a
    // pick between two flops; registering it again would cost a cycle of latency.
    assign rdata_o = fcd_rd_q ? fcd_rdata : reg_rdata_q;

    // violation flag pulse
    // Unmapped addresses count as refused too; the pulse lasts one cycle, so the
    // exception logic must take it at the next edge rather than poll for it.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            violation_o <= 1'b0;
        end else begin
            violation_o <= acc && !allow;
        end
    end

    // Configuration seen by the memory management unit, one cycle behind the
    // register file so the unit only sees a value once the write has landed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seg_ptr_o <= SMAG_REG_RST;
            seg_en_o <= SMAG_SEG_EN_RST;
        end else begin
            seg_ptr_o <= regs[SMAG_SEG_PTR[SMAG_IW-1:0]];
            seg_en_o <= regs[SMAG_SEG_EN[SMAG_IW-1:0]];
        end
    end

    // partition hard-wired
    // No write path reaches this flop; it only restates the fixed boundary, and
    // it keeps the output a flop like every other output of the guard except rdata_o, a pick between two flops.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cless_part_o <= SMAG_CLESS_PART_VAL;
        end else begin
            cless_part_o <= SMAG_CLESS_PART_VAL;
        end
    end
endmodule

// File: smag_pkg.sv
// Constants and types for the peripheral control register access guard.
// Assumes an 8-bit register address space, 8-bit data, one controller clock.
package smag_pkg;
    // CPU modes
    typedef enum logic [1:0] {
        SMAG_SYSTEM,
        SMAG_USER,
        SMAG_TEST,
        SMAG_CLESS
    } smag_mode_e;

    localparam int SMAG_AW = 8;
    localparam int SMAG_DW = 8;
    localparam int SMAG_NREG = 16;          // Held registers at the base of the map
    localparam int SMAG_IW = 4;
    localparam int SMAG_NGRANT = 8;         // Grantable peripheral registers

    // Address map (register index = address)
    localparam logic [7:0] SMAG_CPU_LO = 8'h00;      // CPU core registers 0x00..0x03
    localparam logic [7:0] SMAG_CPU_HI = 8'h03;
    localparam logic [7:0] SMAG_MMU_LO = 8'h04;      // MMU configuration 0x04..0x07
    localparam logic [7:0] SMAG_MMU_HI = 8'h07;
    localparam logic [7:0] SMAG_SEG_PTR = 8'h04;     // Segment table pointer
    localparam logic [7:0] SMAG_SEG_EN = 8'h05;      // Segment enables
    localparam logic [7:0] SMAG_UGRANT = 8'h06;      // User grant bits
    localparam logic [7:0] SMAG_CGRANT = 8'h07;      // Contactless grant bits
    localparam logic [7:0] SMAG_PER_LO = 8'h08;      // Peripheral 0x08..0x0f
    localparam logic [7:0] SMAG_PER_HI = 8'h0f;
    localparam logic [7:0] SMAG_CLESS_PART = 8'h10;  // Fixed contactless partition
    localparam logic [7:0] SMAG_FCD_LO = 8'h20;      // Factory check data 0x20..0x27
    localparam logic [7:0] SMAG_FCD_HI = 8'h27;
    localparam int SMAG_FCD_N = 8;
    localparam int SMAG_FCD_IW = 3;

    // Reset values
    localparam logic [7:0] SMAG_REG_RST = 8'h00;
    localparam logic [7:0] SMAG_SEG_EN_RST = 8'h00;  // No segment usable
    localparam logic [7:0] SMAG_GRANT_RST = 8'h00;   // Nothing opened
    localparam logic [7:0] SMAG_CLESS_PART_VAL = 8'h80; // Fixed partition boundary
    localparam logic [7:0] SMAG_ZERO = 8'h00;
endpackage

// File: smag_fcd_mem.sv
// Small memory holding the factory check data.
// Assumes writes are already qualified by the guard; read data registered.
`timescale 1ns/100ps
module smag_fcd_mem
    import smag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [SMAG_FCD_IW-1:0] addr_i,
    input wire logic [SMAG_DW-1:0] wdata_i,
    output logic [SMAG_DW-1:0] rdata_o
);
    logic [SMAG_DW-1:0] mem [SMAG_FCD_N];

    // Storage, cleared at reset so the contents start defined
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < SMAG_FCD_N; i++) begin
                mem[i] <= SMAG_ZERO;
            end
        end else if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= SMAG_ZERO;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// File: smag_guard_assertions.sv
// Checker of the access guard, seeing its ports only.
// Assumes one clock domain and its active-high reset.
`timescale 1ns/100ps
module smag_guard_chk
    import smag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic test_end_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [SMAG_AW-1:0] addr_i,
    input wire logic [SMAG_DW-1:0] wdata_i,
    input wire logic [SMAG_DW-1:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic violation_o,
    input wire logic [SMAG_DW-1:0] seg_ptr_o,
    input wire logic [SMAG_DW-1:0] seg_en_o,
    input wire logic [SMAG_DW-1:0] cless_part_o
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_MMU_SYS: assert property (
        (rd_i || wr_i) && addr_i inside {[SMAG_MMU_LO:SMAG_MMU_HI]} && mode_i != SMAG_SYSTEM
        |=> violation_o) else $error("mmu access not refused");
    AST_PER_SYS: assert property (
        rd_i && !wr_i && mode_i == SMAG_SYSTEM && addr_i inside {[SMAG_PER_LO:SMAG_PER_HI]}
        |=> rvalid_o && !violation_o) else $error("system peripheral read refused");
    AST_CPU_ANY: assert property (
        (rd_i || wr_i) && addr_i <= SMAG_CPU_HI |=> !violation_o) else $error("cpu reg refused");
    AST_SEG_PTR: assert property (
        wr_i && addr_i == SMAG_SEG_PTR && mode_i == SMAG_SYSTEM
        |-> ##2 seg_ptr_o == $past(wdata_i, 2)) else $error("segment pointer not written");
    AST_PART_FIX: assert property (
        cless_part_o == SMAG_CLESS_PART_VAL) else $error("partition changed");
    AST_FCD_WR: assert property (
        wr_i && addr_i inside {[SMAG_FCD_LO:SMAG_FCD_HI]} && !(mode_i == SMAG_TEST && test_end_i)
        |=> violation_o) else $error("factory write not refused");
    AST_REFUSED_ZERO: assert property (
        rvalid_o && violation_o |-> rdata_o == SMAG_ZERO) else $error("refused read leaks");
    AST_RD_ANSWER: assert property (
        rd_i && !wr_i |=> rvalid_o) else $error("read not answered");
endmodule
bind smag_guard smag_guard_chk u_chk (.clk_i, .rst_i, .mode_i, .test_end_i, .rd_i, .wr_i,
    .addr_i, .wdata_i, .rdata_o, .rvalid_o, .violation_o, .seg_ptr_o, .seg_en_o, .cless_part_o);

// File: smag_cpu_model.sv
// CPU core model issuing single register accesses.
// Assumes the bench calls acc; lines change at the falling edge.
`timescale 1ns/100ps
module smag_cpu_model
    import smag_pkg::*;
(
    input wire logic clk_i,
    output logic [1:0] mode_o,
    output logic test_end_o,
    output logic rd_o,
    output logic wr_o,
    output logic [SMAG_AW-1:0] addr_o,
    output logic [SMAG_DW-1:0] wdata_o
);
    // Idle at time zero
    initial begin
        {mode_o, test_end_o, rd_o, wr_o, addr_o, wdata_o} = '0;
    end
    // Held for one taken edge, then scrambled so stale values are never trusted
    task automatic acc(logic [1:0] m, logic t, logic w, logic [7:0] a, logic [7:0] d);
        @(negedge clk_i);
        {mode_o, test_end_o, rd_o, wr_o, addr_o, wdata_o} = {m, t, !w, w, a, d};
        @(negedge clk_i);
        {rd_o, wr_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    endtask
endmodule

// File: tb_top.sv
// Self-checking bench of the access guard behind a CPU model.
// Assumes the checker binds itself to the guard.
`timescale 1ns/100ps
module tb_top
    import smag_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] mode;
    logic te, rd, wr, rvalid, viol;
    logic [7:0] addr, wdata, rdata, seg_ptr, seg_en, part;
    logic [7:0] sh [0:47] = '{default: 8'h00};
    logic [31:0] seed = 32'h147788a7;
    logic [31:0] r;
    int miscompares = 0;
    int checked = 0;
    // Clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    smag_cpu_model u_smag_cpu_model (.clk_i, .mode_o(mode), .test_end_o(te), .rd_o(rd),
        .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
    smag_guard u_smag_guard (.clk_i, .rst_i, .mode_i(mode), .test_end_i(te), .rd_i(rd),
        .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .violation_o(viol), .seg_ptr_o(seg_ptr), .seg_en_o(seg_en), .cless_part_o(part));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected permission; grants come from the shadow copy
    function automatic logic allowed(logic [1:0] m, logic t, logic w, logic [7:0] a);
        if (a <= SMAG_CPU_HI) return 1'b1;
        if (a <= SMAG_MMU_HI) return m == SMAG_SYSTEM;
        if (a <= SMAG_PER_HI) return m == SMAG_SYSTEM || (m == SMAG_USER && sh[6][a[2:0]])
            || (m == SMAG_CLESS && sh[7][a[2:0]]);
        if (a == SMAG_CLESS_PART) return !w;
        if (a inside {[SMAG_FCD_LO:SMAG_FCD_HI]}) return w ? m == SMAG_TEST && t : m <= 2'h1;
        return 1'b0;
    endfunction
    task automatic cmp(logic [7:0] got, logic [7:0] exp, string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic chk(logic [1:0] m, logic t, logic w, logic [7:0] a, logic [7:0] d);
        logic ok;
        ok = allowed(m, t, w, a);
        u_smag_cpu_model.acc(m, t, w, a, d);
        cmp(8'(viol), 8'(!ok), "violation");
        cmp(8'(rvalid), 8'(!w), "read answer");
        if (!w) cmp(rdata, !ok ? 8'h00 : a == 8'h10 ? 8'h80 : sh[a], "read data");
        if (w && ok) sh[a] = d;
    endtask
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog, far beyond the roughly 840 cycles needed
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    // Directed corners first, then a random mix with unmapped holes
    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        cmp(seg_en, 8'h00, "segment enables");
        cmp(part, 8'h80, "partition");
        for (int i = 0; i < 8; i++) chk(SMAG_TEST, 1'b1, 1'b1, 8'h20 + 8'(i), 8'(xs()));
        chk(SMAG_TEST, 1'b0, 1'b1, SMAG_FCD_LO, 8'h5a);
        chk(SMAG_SYSTEM, 1'b0, 1'b1, SMAG_CLESS_PART, 8'h00);
        chk(SMAG_USER, 1'b0, 1'b1, SMAG_SEG_PTR, 8'hff);
        chk(SMAG_SYSTEM, 1'b0, 1'b1, SMAG_SEG_PTR, 8'h3c);
        @(negedge clk_i);
        cmp(seg_ptr, 8'h3c, "segment pointer write");
        chk(SMAG_USER, 1'b0, 1'b0, SMAG_FCD_LO, 8'h00);
        chk(SMAG_SYSTEM, 1'b0, 1'b1, SMAG_UGRANT, 8'h01);
        chk(SMAG_USER, 1'b0, 1'b0, SMAG_PER_LO, 8'h00);
        chk(SMAG_USER, 1'b0, 1'b0, SMAG_PER_HI, 8'h00);
        repeat (400) begin
            r = xs();
            chk(r[7:6], r[8], r[9], {2'b00, r[5:0] < 6'd48 ? r[5:0] : r[5:0] - 6'd16},
                r[17:10]);
        end
        repeat (2) @(negedge clk_i);
        cmp(seg_ptr, sh[4], "segment pointer");
        cmp(seg_en, sh[5], "segment enables");
        wrap_up();
    end
endmodule
